// >>> bench/swi_core_properties.sv
// Port timing checker of the word interface core
`timescale 1ns/100ps
module swi_core_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Host control pins and the decoder command sync
   input wire logic command_sync_in,
   input wire logic controller_role_select,
   input wire logic transmit_request_pulse,
   input wire logic interrupt_ack_n,
   input wire logic flag_output_enable,
   input wire logic rx_byte_read_strobe_n,
   // Watched outputs
   input wire logic transmit_enable_out,
   input wire logic receive_irq_n,
   input wire logic tx_irq_n,
   input wire logic broadcast_n,
   input wire logic [swi_pkg::BYTE_W-1:0] host_byte_bus_out,
   input wire logic [swi_pkg::BYTE_W-1:0] host_byte_bus_oe,
   input wire swi_pkg::swi_flags_t flag_od_out,
   input wire swi_pkg::swi_flags_t flag_od_oe
);
   import swi_pkg::*;
   // All checks run on the system clock
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // Status pins stay released without the enable
   a_flags_need_enable: assert property (!flag_output_enable [*4] |-> flag_od_oe == '0)
      else $error("status pin driven without enable");
   a_od_drive_low: assert property (flag_od_out == '0 && host_byte_bus_out == '0)
      else $error("open drain pin driven high");
   a_bus_released: assert property (rx_byte_read_strobe_n [*5] |-> host_byte_bus_oe == '0)
      else $error("byte bus driven without read strobe");
   // Header events only land while a command frame is on the line
   a_ack_clears_irqs: assert property ((!interrupt_ack_n && !command_sync_in) [*6]
      |-> receive_irq_n && tx_irq_n && broadcast_n)
      else $error("acknowledge left an interrupt low");
   a_reset_values: assert property ($rose(rst_b) |-> !transmit_enable_out && receive_irq_n
      && tx_irq_n && broadcast_n)
      else $error("outputs not at reset level");
   a_ctrl_tx_set: assert property ($rose(transmit_request_pulse) && !controller_role_select
      && !transmit_enable_out |-> ##[1:6] transmit_enable_out)
      else $error("request pulse did not set transmit enable");
   a_ctrl_tx_clear: assert property ($rose(transmit_request_pulse) && !controller_role_select
      && transmit_enable_out |-> ##[1:6] !transmit_enable_out)
      else $error("request pulse did not clear transmit enable");
   a_ctrl_tx_hold: assert property ((!controller_role_select && !transmit_request_pulse) [*8]
      |-> $stable(transmit_enable_out))
      else $error("transmit enable moved without request");
   // Main scenarios reached
   c_rx_irq: cover property (!receive_irq_n);
   c_tx_enable: cover property ($rose(transmit_enable_out));
   c_bus_read: cover property (host_byte_bus_oe != '0);
endmodule
bind swi_core swi_core_properties u_swi_core_properties (.mclk, .rst_b, .command_sync_in,
   .controller_role_select, .transmit_request_pulse, .interrupt_ack_n, .flag_output_enable,
   .rx_byte_read_strobe_n, .transmit_enable_out, .receive_irq_n, .tx_irq_n, .broadcast_n,
   .host_byte_bus_out, .host_byte_bus_oe, .flag_od_out, .flag_od_oe);

// >>> bench/swi_core_tb_top.sv
// Self-checking bench of the word interface core
`timescale 1ns/100ps
module swi_core_tb_top;
   import swi_pkg::*;
   // Pins of the core
   logic mclk, rst_b, encoder_send_window, tx_bit_clock, controller_role_select;
   logic transmit_request_pulse, interrupt_ack_n, flag_output_enable;
   logic tx_byte_write_strobe_n, rx_byte_read_strobe_n;
   logic [ADDR_W-1:0] terminal_address_in;
   logic [BYTE_W-1:0] host_drv, host_byte_bus_in, host_byte_bus_out, host_byte_bus_oe;
   logic rx_bit_clock, command_sync_in, data_sync_in, serial_rx_in, decoder_word_ok;
   logic serial_tx_out, transmit_enable_out, receive_irq_n, tx_irq_n, broadcast_n;
   swi_flags_t flag_od_out, flag_od_oe;
   logic [5:0] lvl;
   int fails, check_count;
   // Pull-ups resolve the open-drain wires
   assign host_byte_bus_in = host_drv & ~host_byte_bus_oe;
   assign lvl = ~flag_od_oe;
   swi_dec_model u_swi_dec_model (.rx_bit_clock, .command_sync_in, .data_sync_in,
      .serial_rx_in, .decoder_word_ok);
   swi_core u_swi_core (.mclk, .rst_b, .rx_bit_clock, .command_sync_in, .data_sync_in,
      .serial_rx_in, .decoder_word_ok, .encoder_send_window, .tx_bit_clock, .serial_tx_out,
      .transmit_enable_out, .controller_role_select, .transmit_request_pulse,
      .interrupt_ack_n, .flag_output_enable, .terminal_address_in, .tx_byte_write_strobe_n,
      .rx_byte_read_strobe_n, .host_byte_bus_in, .host_byte_bus_out, .host_byte_bus_oe,
      .receive_irq_n, .tx_irq_n, .broadcast_n, .flag_od_out, .flag_od_oe);
   // System clock, 4 ns
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Cycles, then 1 ns past the edge so inputs never race it
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Strobes are held well past the two-flop pin sampling
   task automatic rd(input logic [7:0] exp);
      rx_byte_read_strobe_n = 1'b0;
      cyc(5);
      check(host_byte_bus_in, exp);
      rx_byte_read_strobe_n = 1'b1;
      cyc(5);
   endtask
   task automatic wr(input logic [7:0] b);
      host_drv = b;
      tx_byte_write_strobe_n = 1'b0;
      cyc(4);
      tx_byte_write_strobe_n = 1'b1;
      cyc(4);
      host_drv = 8'hFF;
   endtask
   task automatic ack();
      interrupt_ack_n = 1'b0;
      cyc(6);
      interrupt_ack_n = 1'b1;
      cyc(4);
   endtask
   task automatic pulse();
      transmit_request_pulse = 1'b1;
      cyc(4);
      transmit_request_pulse = 1'b0;
      cyc(6);
   endtask
   task automatic word(input logic cmd, input logic [15:0] w, input logic ok);
      u_swi_dec_model.send_word(cmd, w, ok);
      cyc(6);
   endtask
   task automatic t_rx_cmd();
      controller_role_select = 1'b1;
      word(1'b1, 16'h5000, 1'b1);
      check({receive_irq_n, tx_irq_n}, 2'h1);
      check(lvl[5:4], 2'h3);
      check(lvl[2], 1'b0);
      rd(8'h50);
      rd(8'h00);
      u_swi_dec_model.idle(32);
      cyc(6);
      check(receive_irq_n, 1'b1);
   endtask
   // full message after the zero-count receive command
   task automatic t_rx_msg();
      for (int i = 0; i < 32; i++) begin
         check(lvl[0], 1'b1);
         word(1'b0, 16'h1234, 1'b1);
      end
      check({lvl[0], transmit_enable_out}, 2'h1);
      encoder_send_window = 1'b1;
      cyc(6);
      check(transmit_enable_out, 1'b0);
      encoder_send_window = 1'b0;
      cyc(6);
   endtask
   task automatic t_bcast();
      word(1'b1, 16'hF821, 1'b1);
      check({broadcast_n, receive_irq_n}, 2'h1);
      ack();
      check({broadcast_n, lvl[5:4]}, 3'h4);
   endtask
   task automatic t_tx_cmd();
      word(1'b1, 16'h5821, 1'b1);
      check(receive_irq_n, 1'b1);
      word(1'b1, 16'h5460, 1'b1);
      check({receive_irq_n, tx_irq_n, lvl[5:4]}, 4'h9);
      ack();
      check({receive_irq_n, tx_irq_n, lvl[5:4]}, 4'hC);
      pulse();
      check(transmit_enable_out, 1'b1);
      pulse();
      check(transmit_enable_out, 1'b0);
   endtask
   task automatic t_ctrl_rx();
      controller_role_select = 1'b0;
      word(1'b0, 16'hA5C3, 1'b0);
      check(lvl[3:2], 2'h3);
      flag_output_enable = 1'b0;
      cyc(4);
      check(flag_od_oe, 16'h0000);
      flag_output_enable = 1'b1;
      cyc(4);
      rd(8'hA5);
      rd(8'hC3);
      word(1'b0, 16'h0F0F, 1'b1);
      check(lvl[3:2], 2'h1);
   endtask
   task automatic t_ctrl_tx();
      logic [15:0] r;
      pulse();
      check(transmit_enable_out, 1'b1);
      wr(8'h96);
      wr(8'h3C);
      check(lvl[1], 1'b0);
      encoder_send_window = 1'b1;
      cyc(6);
      check(lvl[1], 1'b1);
      for (int i = 0; i < 16; i++) begin
         r = {r[14:0], serial_tx_out};
         tx_bit_clock = 1'b1;
         cyc(6);
         tx_bit_clock = 1'b0;
         cyc(6);
      end
      check(r, 16'h963C);
      encoder_send_window = 1'b0;
      pulse();
      check(transmit_enable_out, 1'b0);
   endtask
   // Main sequence; reset also spans a few link clocks
   initial begin
      {encoder_send_window, tx_bit_clock, controller_role_select} = 3'h0;
      {transmit_request_pulse, rst_b, fails, check_count} = '0;
      {interrupt_ack_n, flag_output_enable, tx_byte_write_strobe_n} = 3'h7;
      rx_byte_read_strobe_n = 1'b1;
      terminal_address_in = 5'h0A;
      host_drv = 8'hFF;
      fork
         u_swi_dec_model.idle(3);
         repeat (12) @(posedge mclk);
      join
      #1 rst_b = 1'b1;
      cyc(3);
      check({receive_irq_n, tx_irq_n, broadcast_n, transmit_enable_out}, 4'hE);
      check(lvl, 6'h03);
      t_rx_cmd();
      t_rx_msg();
      t_bcast();
      t_tx_cmd();
      t_ctrl_rx();
      t_ctrl_tx();
      test_done();
   end
endmodule

// >>> bench/swi_dec_model.sv
// Decoder side model: receive clock, sync envelopes, serial data, word verdict
`timescale 1ns/100ps
module swi_dec_model (
   // Decoder pins
   output logic rx_bit_clock,
   output logic command_sync_in,
   output logic data_sync_in,
   output logic serial_rx_in,
   output logic decoder_word_ok
);
   import swi_pkg::*;
   // Link clock stands still low between frames except while idle clocks are sent
   initial begin
      {rx_bit_clock, command_sync_in, data_sync_in, serial_rx_in, decoder_word_ok} = 5'h00;
   end
   // One receive clock of 15 ns
   task automatic tick();
      #7.5 rx_bit_clock = 1'b1;
      #7.5 rx_bit_clock = 1'b0;
   endtask
   // Quiet line clocks
   task automatic idle(input int n);
      repeat (n) tick();
   endtask
   // One word; cmd picks the sync line, ok is the verdict
   task automatic send_word(input logic cmd, input logic [WORD_W-1:0] w, input logic ok);
      for (int i = WORD_W - 1; i >= 0; i--) begin
         command_sync_in = cmd;
         data_sync_in = !cmd;
         serial_rx_in = w[i];
         tick();
      end
      command_sync_in = 1'b0;
      data_sync_in = 1'b0;
      // Released data line shows the inverse, never the last bit
      serial_rx_in = ~w[0];
      #7.5 rx_bit_clock = 1'b1;
      // verdict after first clock past sync fall
      decoder_word_ok = ok;
      #7.5 rx_bit_clock = 1'b0;
      tick();
      decoder_word_ok = 1'b0;
   endtask
endmodule

// >>> src/swi_core.sv
// Word interface core: receive shifter on the link clock, host side on mclk
`timescale 1ns/100ps
module swi_core (
   // System clock and power-up reset
   input wire logic mclk,
   input wire logic rst_b,
   // Decoder side, on the receive clock
   input wire logic rx_bit_clock,
   input wire logic command_sync_in,
   input wire logic data_sync_in,
   input wire logic serial_rx_in,
   input wire logic decoder_word_ok,
   // Encoder side
   input wire logic encoder_send_window,
   input wire logic tx_bit_clock,
   output logic serial_tx_out,
   output logic transmit_enable_out,
   // Host control
   input wire logic controller_role_select,
   input wire logic transmit_request_pulse,
   input wire logic interrupt_ack_n,
   input wire logic flag_output_enable,
   input wire logic [swi_pkg::ADDR_W-1:0] terminal_address_in,
   // Host byte bus, open drain
   input wire logic tx_byte_write_strobe_n,
   input wire logic rx_byte_read_strobe_n,
   input wire logic [swi_pkg::BYTE_W-1:0] host_byte_bus_in,
   output logic [swi_pkg::BYTE_W-1:0] host_byte_bus_out,
   output logic [swi_pkg::BYTE_W-1:0] host_byte_bus_oe,
   // Interrupt and broadcast lines, active low
   output logic receive_irq_n,
   output logic tx_irq_n,
   output logic broadcast_n,
   // Open-drain status pins
   output swi_pkg::swi_flags_t flag_od_out,
   output swi_pkg::swi_flags_t flag_od_oe
);
   import swi_pkg::*;

   // State of the receive-clock domain
   typedef struct packed {
      logic [WORD_W-1:0] shift;
      logic [CNT_W-1:0] cnt;
      logic cmd_env;
      logic prev_sync;
      logic [WORD_W-1:0] word;
      logic word_cmd;
      logic word_ok;
      logic vw_wait;
      logic done_tgl;
      logic [HDR_W-1:0] hdr;
      logic hdr_tgl;
      logic [CNT_W-1:0] idle_cnt;
      logic idle_arm;
      logic idle_tgl;
   } swi_rx_t;

   // State of the system-clock domain
   typedef struct packed {
      swi_pins_t prev;
      swi_flags_t flags;
      swi_flags_t od_oe;
      logic rx_irq_n;
      logic tx_irq_n;
      logic bcast_n;
      logic [WORD_W-1:0] rx_buf;
      logic rd_phase;
      logic rd_drive;
      logic [BYTE_W-1:0] rd_byte;
      logic [BYTE_W-1:0] bus_oe;
      logic [WORD_W-1:0] tx_buf;
      logic wr_phase;
      logic [WORD_W-1:0] tx_shift;
      logic tx_bit;
      logic txen;
      logic clr_at_sd;
      logic tx_pending;
      swi_msg_t mode;
      logic [CNT_W-1:0] exp;
      logic [CNT_W-1:0] cnt;
   } swi_st_t;

   swi_rx_t r;
   swi_rx_t next_r;
   swi_st_t s;
   swi_st_t next_s;
   swi_pins_t p;
   swi_pins_t pins_raw;
   logic ev_done;
   logic ev_hdr;
   logic ev_idle;
   logic rx_sync;
   logic terminal;
   logic hdr_match;
   logic word_match;
   logic [CNT_W-1:0] wc_words;
   logic sd_rise;
   logic sd_fall;
   logic tx_bit_clock_fall;
   logic req_rise;
   logic wr_fall;
   logic rd_fall;
   logic rd_rise;

   // Receive domain: either sync frames one word
   assign rx_sync = command_sync_in | data_sync_in;

   // Receive shifter, header and word events
   always_comb begin
      next_r = r;
      next_r.prev_sync = rx_sync;
      if (rx_sync) begin
         next_r.shift = {r.shift[WORD_W-2:0], serial_rx_in};
         if (r.cnt != BITS_PER_WORD) begin
            next_r.cnt = r.cnt + CNT_ONE;
         end
         if (!r.prev_sync) begin
            next_r.cmd_env = command_sync_in;
         end
         if (command_sync_in && r.cnt == HDR_LAST_CNT) begin
            next_r.hdr = {r.shift[HDR_W-2:0], serial_rx_in};
            next_r.hdr_tgl = ~r.hdr_tgl;
         end
      end else begin
         next_r.cnt = CNT_ZERO;
      end
      // word ends when the sync envelope falls
      if (!rx_sync && r.prev_sync) begin
         next_r.word = r.shift;
         next_r.word_cmd = r.cmd_env;
         next_r.vw_wait = 1'b1;
      end
      // word ok taken one clock after the fall was seen
      if (r.vw_wait) begin
         next_r.vw_wait = 1'b0;
         next_r.word_ok = decoder_word_ok;
         next_r.done_tgl = ~r.done_tgl;
      end
      // Idle line: no new sync within the count after a sync rose
      if (rx_sync && !r.prev_sync) begin
         next_r.idle_cnt = CNT_ZERO;
         next_r.idle_arm = 1'b1;
      end else if (r.idle_arm) begin
         next_r.idle_cnt = r.idle_cnt + CNT_ONE;
         if (r.idle_cnt == IDLE_LAST) begin
            next_r.idle_arm = 1'b0;
            next_r.idle_tgl = ~r.idle_tgl;
         end
      end
   end

   // async low reset of the receive domain
   always_ff @(posedge rx_bit_clock or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Events cross by toggles; data beside them is stable by then
   swi_evt_rx u_ev_done (
      .clk(mclk),
      .rst_b(rst_b),
      .tgl(r.done_tgl),
      .pulse(ev_done)
   );

   swi_evt_rx u_ev_hdr (
      .clk(mclk),
      .rst_b(rst_b),
      .tgl(r.hdr_tgl),
      .pulse(ev_hdr)
   );

   swi_evt_rx u_ev_idle (
      .clk(mclk),
      .rst_b(rst_b),
      .tgl(r.idle_tgl),
      .pulse(ev_idle)
   );

   // All host and encoder pins pass two flops
   assign pins_raw = '{flag_output_enable, interrupt_ack_n, encoder_send_window,
                       tx_bit_clock, controller_role_select, transmit_request_pulse,
                       tx_byte_write_strobe_n, rx_byte_read_strobe_n,
                       host_byte_bus_in, terminal_address_in};

   swi_sync #(.W($bits(swi_pins_t)), .INIT(PINS_IDLE)) u_pins (
      .clk(mclk),
      .rst_b(rst_b),
      .d(pins_raw),
      .q(p)
   );

   // Edges of the synchronised pins
   assign sd_rise = p.encoder_send_window & ~s.prev.encoder_send_window;
   assign sd_fall = ~p.encoder_send_window & s.prev.encoder_send_window;
   assign tx_bit_clock_fall = ~p.tx_bit_clock & s.prev.tx_bit_clock;
   assign req_rise = p.transmit_request_pulse & ~s.prev.transmit_request_pulse;
   assign wr_fall = ~p.tx_byte_write_strobe_n & s.prev.tx_byte_write_strobe_n;
   assign rd_fall = ~p.rx_byte_read_strobe_n & s.prev.rx_byte_read_strobe_n;
   assign rd_rise = p.rx_byte_read_strobe_n & ~s.prev.rx_byte_read_strobe_n;

   assign terminal = p.controller_role_select;
   assign hdr_match = r.hdr[HDR_W-1:1] == p.terminal_address_in;
   assign word_match = r.word[ADDR_LO +: ADDR_W] == p.terminal_address_in;
   assign wc_words = (r.word[WC_LO +: FIELD_W] == FIELD_ZERO) ? WC_ZERO_WORDS
                     : {1'b0, r.word[WC_LO +: FIELD_W]};

   // Host side: ack and idle clears are applied first so that header and word sets win
   always_comb begin
      next_s = s;
      next_s.prev = p;
      // ack and idle clear irqs, zero flags and broadcast
      if (!p.interrupt_ack_n || ev_idle) begin
         next_s.rx_irq_n = 1'b1;
         next_s.tx_irq_n = 1'b1;
         next_s.bcast_n = 1'b1;
         next_s.flags.zero_subaddress_flag = 1'b0;
         next_s.flags.zero_count_flag = 1'b0;
      end
      // upper byte on first read, lower on second
      if (rd_fall) begin
         next_s.rd_byte = s.rd_phase ? s.rx_buf[BYTE_W-1:0]
                          : s.rx_buf[WORD_W-1:HI_LO];
         next_s.rd_drive = 1'b1;
         next_s.rd_phase = ~s.rd_phase;
         if (s.rd_phase) begin
            next_s.flags.word_available = 1'b0;
         end
      end
      if (rd_rise) begin
         next_s.rd_drive = 1'b0;
      end
      // broadcast address seen in the header
      if (ev_hdr) begin
         if (r.hdr[HDR_W-1:1] == ADDR_BCAST) begin
            next_s.bcast_n = 1'b0;
         end
         if (hdr_match) begin
            if (!r.hdr[0]) begin
               next_s.rx_irq_n = 1'b0;
            end else begin
               next_s.tx_irq_n = 1'b0;
               next_s.tx_pending = 1'b1;
               if (terminal) begin
                  next_s.tx_buf = {p.terminal_address_in, JAM_TAIL};
                  next_s.wr_phase = 1'b0;
               end
            end
         end
      end
      // Completed received word
      if (ev_done) begin
         next_s.rx_buf = r.word;
         next_s.rd_phase = 1'b0;
         // role decides which words are announced
         if (!terminal || !r.word_cmd) begin
            next_s.flags.word_available = 1'b1;
         end
         next_s.flags.invalid_word_flag = ~r.word_ok;
         if (r.word_cmd) begin
            if (r.word[SA_LO +: FIELD_W] == FIELD_ZERO) begin
               next_s.flags.zero_subaddress_flag = 1'b1;
            end
            if (r.word[WC_LO +: FIELD_W] == FIELD_ZERO) begin
               next_s.flags.zero_count_flag = 1'b1;
            end
            if (terminal && word_match && s.mode == SWI_IDLE) begin
               next_s.mode = r.word[ADDR_LO-1] ? SWI_TX_MSG : SWI_RX_MSG;
               next_s.exp = wc_words;
               next_s.cnt = CNT_ZERO;
               next_s.flags.message_done_n = 1'b1;
            end
         end else if (terminal && s.mode == SWI_RX_MSG) begin
            next_s.cnt = s.cnt + CNT_ONE;
            if (s.cnt + CNT_ONE == s.exp) begin
               next_s.flags.message_done_n = 1'b0;
               next_s.mode = SWI_IDLE;
               // answer enabled after the last data word
               next_s.txen = 1'b1;
               next_s.clr_at_sd = 1'b1;
            end
         end
      end
      // upper byte on first write, lower on second
      if (wr_fall) begin
         if (!s.wr_phase) begin
            next_s.tx_buf[WORD_W-1:HI_LO] = p.host_byte_bus;
         end else begin
            next_s.tx_buf[BYTE_W-1:0] = p.host_byte_bus;
            next_s.flags.tx_holding_free = 1'b0;
         end
         next_s.wr_phase = ~s.wr_phase;
      end
      // Transmit request pulse
      if (req_rise) begin
         if (!terminal) begin
            next_s.txen = ~s.txen;
            if (!s.txen) begin
               next_s.cnt = CNT_ZERO;
               next_s.flags.message_done_n = 1'b1;
            end
         end else if (s.txen) begin
            next_s.txen = 1'b0;
         end else if (s.tx_pending) begin
            // pulse after transmit irq starts transmission
            next_s.txen = 1'b1;
            next_s.tx_pending = 1'b0;
         end
      end
      // parallel load while the send window is low
      if (!p.encoder_send_window) begin
         next_s.tx_shift = s.tx_buf;
      end else if (tx_bit_clock_fall) begin
         next_s.tx_shift = {s.tx_shift[WORD_W-2:0], 1'b0};
      end
      if (sd_rise) begin
         // buffer consumed, host may write again
         next_s.flags.tx_holding_free = 1'b1;
         next_s.wr_phase = 1'b0;
         // enable cleared in the next send window
         if (s.clr_at_sd) begin
            next_s.txen = 1'b0;
            next_s.clr_at_sd = 1'b0;
         end
         // last data word's window clears the enable
         if (terminal && s.mode == SWI_TX_MSG && s.cnt == s.exp) begin
            next_s.txen = 1'b0;
         end
      end
      // Count words sent; status word comes before the data words
      if (sd_fall) begin
         next_s.cnt = s.cnt + CNT_ONE;
         // controller message ends after its fixed count
         if (!terminal && s.cnt + CNT_ONE == BC_MSG_WORDS) begin
            next_s.flags.message_done_n = 1'b0;
         end
         // terminal message ends after status plus data words
         if (terminal && s.mode == SWI_TX_MSG && s.cnt == s.exp) begin
            next_s.flags.message_done_n = 1'b0;
            next_s.mode = SWI_IDLE;
         end
      end
      next_s.tx_bit = next_s.tx_shift[WORD_W-1];
      // open-drain bus pulls low only where the byte has zeros
      next_s.bus_oe = next_s.rd_drive ? ~next_s.rd_byte : BYTE_ZERO;
      // status pins pull low only while enabled
      next_s.od_oe = p.flag_output_enable ? ~next_s.flags : '0;
   end

   // async low reset of the host domain
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{prev: PINS_IDLE, flags: FLAGS_RST, od_oe: '0, rx_irq_n: 1'b1,
                tx_irq_n: 1'b1, bcast_n: 1'b1, mode: SWI_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from flops; open-drain data levels are low
   assign serial_tx_out = s.tx_bit;
   assign transmit_enable_out = s.txen;
   assign receive_irq_n = s.rx_irq_n;
   assign tx_irq_n = s.tx_irq_n;
   assign broadcast_n = s.bcast_n;
   assign host_byte_bus_oe = s.bus_oe;
   assign host_byte_bus_out = s.prev.host_byte_bus & BYTE_ZERO;
   assign flag_od_oe = s.od_oe;
   assign flag_od_out = s.od_oe & '0;
endmodule

// >>> src/swi_evt_rx.sv
// Toggle-to-pulse receiver for events crossing into the system clock
`timescale 1ns/100ps
module swi_evt_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Toggle from the far domain, one-cycle pulse here
   input wire logic tgl,
   output logic pulse
);
   logic tgl_q;
   logic tgl_last;

   swi_sync #(.W(1), .INIT(1'b0)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(tgl),
      .q(tgl_q)
   );

   // Remember the last toggle level seen
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_last <= 1'b0;
      end else begin
         tgl_last <= tgl_q;
      end
   end

   assign pulse = tgl_q ^ tgl_last;
endmodule

// >>> src/swi_pkg.sv
// Shared constants and types of the serial avionics word interface
package swi_pkg;
   // Word and field geometry, bit 1 of the serial word lands in bit 15
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 5;
   localparam int FIELD_W = 5;
   localparam int CNT_W = 6;
   localparam int HDR_W = 6;
   localparam int ADDR_LO = 11;
   localparam int SA_LO = 5;
   localparam int WC_LO = 0;
   localparam int HI_LO = 8;

   // Receive clock counts
   localparam logic [CNT_W-1:0] HDR_LAST_CNT = 6'h05;
   localparam logic [CNT_W-1:0] BITS_PER_WORD = 6'h10;
   localparam logic [CNT_W-1:0] IDLE_CLKS = 6'h20;
   localparam logic [CNT_W-1:0] IDLE_LAST = IDLE_CLKS - 6'h01;

   // Message word counts
   localparam logic [CNT_W-1:0] WC_ZERO_WORDS = 6'h20;
   localparam logic [CNT_W-1:0] BC_MSG_WORDS = 6'h21;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [FIELD_W-1:0] FIELD_ZERO = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_BCAST = 5'h1F;
   localparam logic [WORD_W-ADDR_W-1:0] JAM_TAIL = 11'h000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   // Message progress of the terminal role
   typedef enum logic [1:0] {SWI_IDLE, SWI_RX_MSG, SWI_TX_MSG} swi_msg_t;

   // Open-drain status group, one bit per pin
   typedef struct packed {
      logic zero_subaddress_flag;
      logic zero_count_flag;
      logic invalid_word_flag;
      logic word_available;
      logic tx_holding_free;
      logic message_done_n;
   } swi_flags_t;

   // Pins that are sampled on the system clock
   typedef struct packed {
      logic flag_output_enable;
      logic interrupt_ack_n;
      logic encoder_send_window;
      logic tx_bit_clock;
      logic controller_role_select;
      logic transmit_request_pulse;
      logic tx_byte_write_strobe_n;
      logic rx_byte_read_strobe_n;
      logic [BYTE_W-1:0] host_byte_bus;
      logic [ADDR_W-1:0] terminal_address_in;
   } swi_pins_t;

   // Idle pin levels, so that no false strobe edge shows after reset
   localparam swi_pins_t PINS_IDLE = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                                       1'b1, 1'b1, 8'h00, 5'h00};
   localparam swi_flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
endpackage

// >>> src/swi_sync.sv
// Two-flop level synchroniser with a constant reset value
`timescale 1ns/100ps
module swi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Level from another domain and its safe copy
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
